// File: src/cms_pkg.sv
package cms_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int             CNT_W_DEF      = 16;
   localparam int             DEC_W          = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0]     OFS_MODE       = 8'h00;
   localparam logic [7:0]     OFS_POL        = 8'h04;
   localparam logic [7:0]     OFS_LOAD       = 8'h08;
   localparam logic [7:0]     OFS_HOLD       = 8'h0C;
   localparam logic [7:0]     OFS_CMD        = 8'h10;
   localparam logic [7:0]     OFS_STATUS     = 8'h14;
   localparam logic [7:0]     OFS_COUNT      = 8'h18;

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int             GATE_MSB       = 15;
   localparam int             GATE_LSB       = 13;
   localparam int             SPECIAL_BIT    = 7;
   localparam int             RELOAD_BIT     = 6;
   localparam int             REPEAT_BIT     = 5;
   localparam int             MODE_W         = 16;
   localparam int             POL_SRC_BIT    = 0;
   localparam int             POL_GATE_BIT   = 1;
   localparam int             CMD_ARM_BIT    = 0;
   localparam int             CMD_DISARM_BIT = 1;
   localparam int             CMD_LOAD_BIT   = 2;
   localparam int             ST_ARMED_BIT   = 0;
   localparam int             ST_TC_BIT      = 1;
   localparam int             ST_RUN_BIT     = 2;
   localparam int             ST_SECOND_BIT  = 3;
   localparam int             ST_RSVD_BIT    = 4;
   localparam int             ST_IDX_LSB     = 8;
   localparam int             GATE_LEVEL_BIT = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [15:0]    MODE_RST       = 16'h0000;
   localparam logic [1:0]     POL_RST        = 2'h3;
   localparam logic [15:0]    LOAD_RST       = 16'h0000;
   localparam logic [15:0]    HOLD_RST       = 16'h0000;
   localparam logic [15:0]    COUNT_RST      = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   // gate field and mode letters (A = 0 ... X = 23)
   localparam logic [2:0]     GATE_NONE      = 3'h0;
   localparam logic [4:0]     IDX_M          = 5'h0C;
   localparam logic [4:0]     IDX_P          = 5'h0F;
   localparam logic [4:0]     IDX_T          = 5'h13;
   localparam logic [4:0]     IDX_U          = 5'h14;
   localparam logic [4:0]     IDX_W          = 5'h16;

   typedef enum logic [1:0] {GK_NONE, GK_LEVEL, GK_EDGE} cms_gate_kind_t;
   typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_RUN}   cms_seq_state_t;

endpackage

// File: src/cms_edge_det.sv
`timescale 1ns/1ns
module cms_edge_det (
   input  wire logic clk,        // ref clock
   input  wire logic rst,        // sync reset, high
   input  wire logic ce,         // clock enable
   input  wire logic level,      // sampled input
   input  wire logic activeHigh, // 1: rising is active
   output logic      edgePulse   // active-going edge seen
);

   logic prev;
   logic primed;
   logic next_prev;
   logic next_primed;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_prev   = prev;
      next_primed = primed;
      if (ce) begin
         next_prev   = level;
         next_primed = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev   <= 1'b0;
         primed <= 1'b0;
      end else begin
         prev   <= next_prev;
         primed <= next_primed;
      end
   end

   // only the move toward the active level counts
   assign edgePulse = ce & primed & (level != prev) & (level == activeHigh);

endmodule

// File: src/cms_sequencer.sv
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
// Overview of operation
// - Mode letter comes from gate field plus special, reload and repetition bits.
// - Repetition zero disarms after terminal count; one keeps counting.
// - Gate field zero: gate never qualifies counting; source edges count while armed, except in reserved letters M and P.
// - Level gating: count source edges only while gate is active.
// - Edge gating single-cycle, except capture modes: start on gate edge, stop at next terminal count.
// - Double-cycle modes reach terminal count twice, then disarm when repetition is zero.
// - Alternating modes reload from hold and load in turn.
// - Gate-selected modes reload from load when gate low, hold when high.
// - Capture modes: gate edge copies counter to hold, then reloads from load.
// - Only transitions toward the active polarity are edges.
// - Terminal count takes the next source edge unless a capture gate edge comes in the same cycle; stops follow it.
// - Mode A counts after arming, reloads from load and disarms on the source edge after terminal count.
// - Reload source bit picks load-only versus hold-involving reload modes.
module cms_sequencer #(
   parameter int CNT_W = cms_pkg::CNT_W_DEF // counter width, at most 32
) (
   input  wire logic              ref_clk,   // clock, 250 MHz
   input  wire logic              rst,       // sync reset, high
   input  wire logic              ce,        // clock enable
   input  wire logic              hsel,      // slave select
   input  wire logic [31:0]       haddr,     // byte address
   input  wire logic [1:0]        htrans,    // transfer type
   input  wire logic              hwrite,    // write not read
   input  wire logic [2:0]        hsize,     // transfer size
   input  wire logic [31:0]       hwdata,    // write data
   input  wire logic              hready,    // bus ready
   output logic                   hreadyout, // slave ready
   output logic                   hresp,     // always okay
   output logic [31:0]            hrdata,    // read data
   input  wire logic              srcIn,     // count source
   input  wire logic              gateIn,    // gate input
   output logic                   tcOut,     // terminal count state
   output logic                   armedOut,  // counter armed
   output logic [CNT_W-1:0]       countOut   // counter value
);
   import cms_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // decoding helpers
   function automatic logic regHit(input logic [DEC_W-1:0] a, input logic [7:0] ofs);
      regHit = (a[DEC_W-1:2] == ofs[DEC_W-1:2]);
   endfunction

   function automatic cms_gate_kind_t gateKind(input logic [2:0] g);
      if (g == GATE_NONE)
         gateKind = GK_NONE;
      else if (g[GATE_LEVEL_BIT])
         gateKind = GK_LEVEL;
      else
         gateKind = GK_EDGE;
   endfunction

   function automatic logic [4:0] modeIndex(input logic [MODE_W-1:0] m);
      logic [4:0] k;
      k = 5'h00;
      case (gateKind(m[GATE_MSB:GATE_LSB]))
         GK_LEVEL: k = 5'h01;
         GK_EDGE:  k = 5'h02;
         default:  k = 5'h00;
      endcase
      modeIndex = 5'({2'b00, m[SPECIAL_BIT], m[RELOAD_BIT], m[REPEAT_BIT]} * 3) + k;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // state
   // bus data-phase bookkeeping
   logic [DEC_W-1:0]   regAddr;
   logic               wrPend;
   logic               rdPend;
   logic [DEC_W-1:0]   next_regAddr;
   logic               next_wrPend;
   logic               next_rdPend;
   logic [31:0]        next_hrdata;
   logic [31:0]        rdMux;

   // sequencer state and programmed registers
   cms_seq_state_t     st;
   cms_seq_state_t     next_st;
   logic [MODE_W-1:0]  mode;
   logic [1:0]         pol;
   logic [CNT_W-1:0]   loadReg;
   logic [CNT_W-1:0]   holdReg;
   logic [CNT_W-1:0]   counter;
   logic               tc;
   logic               secondHalf;
   logic [MODE_W-1:0]  next_mode;
   logic [1:0]         next_pol;
   logic [CNT_W-1:0]   next_load;
   logic [CNT_W-1:0]   next_hold;
   logic [CNT_W-1:0]   next_counter;
   logic               next_tc;
   logic               next_second;

   // decoded controls and per-cycle qualifiers
   logic               srcEdge;
   logic               gateEdge;
   logic               wrEn;
   logic               cmdWr;
   cms_gate_kind_t     kind;
   logic [4:0]         modeIdx;
   logic               reservedMode;
   logic               captureMode;
   logic               gateSelMode;
   logic               altMode;
   logic               repeatOn;
   logic               edgeTrig;
   logic               gateActive;
   logic               enabled;
   logic               countOk;
   logic [CNT_W-1:0]   reloadVal;
   logic               finish;
   logic [CNT_W-1:0]   decVal;

   ////////////////////////////////////////////////////////////////////////////////
   // input edge detection
   cms_edge_det u_src (
      .clk        (ref_clk),
      .rst        (rst),
      .ce         (ce),
      .level      (srcIn),
      .activeHigh (pol[POL_SRC_BIT]),
      .edgePulse  (srcEdge)
   );

   cms_edge_det u_gate (
      .clk        (ref_clk),
      .rst        (rst),
      .ce         (ce),
      .level      (gateIn),
      .activeHigh (pol[POL_GATE_BIT]),
      .edgePulse  (gateEdge)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // bus slave: writes land in the data phase, reads take one wait state
   assign hreadyout = ce & ~rdPend;
   assign hresp     = 1'b0;
   assign wrEn      = ce & wrPend;
   assign cmdWr     = wrEn & regHit(regAddr, OFS_CMD);

   always_comb begin
      rdMux = 32'h00000000;
      if (regHit(regAddr, OFS_MODE))
         rdMux = 32'(mode);
      else if (regHit(regAddr, OFS_POL))
         rdMux = 32'(pol);
      else if (regHit(regAddr, OFS_LOAD))
         rdMux = 32'(loadReg);
      else if (regHit(regAddr, OFS_HOLD))
         rdMux = 32'(holdReg);
      else if (regHit(regAddr, OFS_STATUS)) begin
         rdMux[ST_ARMED_BIT]                = (st != SQ_IDLE);
         rdMux[ST_TC_BIT]                   = tc;
         rdMux[ST_RUN_BIT]                  = (st == SQ_RUN);
         rdMux[ST_SECOND_BIT]               = secondHalf;
         rdMux[ST_RSVD_BIT]                 = reservedMode;
         rdMux[ST_IDX_LSB+4:ST_IDX_LSB]     = modeIdx;
      end else if (regHit(regAddr, OFS_COUNT))
         rdMux = 32'(counter);
   end

   always_comb begin
      next_regAddr = regAddr;
      next_wrPend  = wrPend;
      next_rdPend  = rdPend;
      next_hrdata  = hrdata;
      if (ce) begin
         next_wrPend = 1'b0;
         next_rdPend = 1'b0;
         if (rdPend)
            next_hrdata = rdMux;
         if (hsel && htrans[1] && hready) begin
            next_regAddr = haddr[DEC_W-1:0];
            next_wrPend  = hwrite;
            next_rdPend  = ~hwrite;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         regAddr <= '0;
         wrPend  <= 1'b0;
         rdPend  <= 1'b0;
         hrdata  <= 32'h00000000;
      end else begin
         regAddr <= next_regAddr;
         wrPend  <= next_wrPend;
         rdPend  <= next_rdPend;
         hrdata  <= next_hrdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // mode decode
   assign kind         = gateKind(mode[GATE_MSB:GATE_LSB]);
   assign modeIdx      = modeIndex(mode);
   assign reservedMode = (modeIdx == IDX_M) | (modeIdx == IDX_P) | (modeIdx == IDX_T)
                       | (modeIdx == IDX_U) | (modeIdx == IDX_W);
   assign captureMode  = mode[SPECIAL_BIT] & ~mode[RELOAD_BIT];
   assign gateSelMode  = mode[SPECIAL_BIT] & mode[RELOAD_BIT];
   assign altMode      = ~mode[SPECIAL_BIT] & mode[RELOAD_BIT];
   assign repeatOn     = mode[REPEAT_BIT];
   assign edgeTrig     = (kind == GK_EDGE) & ~captureMode;
   assign gateActive   = (gateIn == pol[POL_GATE_BIT]);
   assign enabled      = (st == SQ_RUN) | ((st == SQ_WAIT) & ~edgeTrig);
   assign countOk      = enabled & ~reservedMode
                       & ((kind != GK_LEVEL) | gateActive);
   assign decVal       = counter - CNT_W'(1);

   ////////////////////////////////////////////////////////////////////////////////
   // sequencing
   always_comb begin
      next_st      = st;
      next_mode    = mode;
      next_pol     = pol;
      next_load    = loadReg;
      next_hold    = holdReg;
      next_counter = counter;
      next_tc      = tc;
      next_second  = secondHalf;
      reloadVal    = loadReg;
      finish       = 1'b1;
      if (altMode) begin
         reloadVal = secondHalf ? loadReg : holdReg;
         finish    = secondHalf;
      end else if (gateSelMode) begin
         reloadVal = gateIn ? holdReg : loadReg;
      end
      if (ce) begin
         if (wrEn && regHit(regAddr, OFS_MODE))
            next_mode = hwdata[MODE_W-1:0];
         if (wrEn && regHit(regAddr, OFS_POL))
            next_pol = hwdata[1:0];
         if (wrEn && regHit(regAddr, OFS_LOAD))
            next_load = hwdata[CNT_W-1:0];
         if (wrEn && regHit(regAddr, OFS_HOLD))
            next_hold = hwdata[CNT_W-1:0];
         if (st == SQ_WAIT && edgeTrig && gateEdge)
            next_st = SQ_RUN;
         if (captureMode && gateEdge && st != SQ_IDLE && !reservedMode) begin
            next_hold    = counter;
            next_counter = loadReg;
            next_tc      = 1'b0;
         end else if (srcEdge && tc) begin
            // leaving terminal count: counted unless a capture gate edge wins, stop only afterwards
            next_counter = reloadVal;
            next_tc      = 1'b0;
            if (altMode)
               next_second = ~secondHalf;
            if (finish && !repeatOn)
               next_st = SQ_IDLE;
            else if (finish && edgeTrig && st != SQ_IDLE)
               next_st = SQ_WAIT;
         end else if (srcEdge && countOk) begin
            next_counter = decVal;
            next_tc      = (decVal == '0);
         end
         // commands come last so load and arm override counting
         if (cmdWr && hwdata[CMD_LOAD_BIT]) begin
            next_counter = loadReg;
            next_tc      = 1'b0;
         end
         if (cmdWr && hwdata[CMD_DISARM_BIT])
            next_st = SQ_IDLE;
         if (cmdWr && hwdata[CMD_ARM_BIT] && next_st == SQ_IDLE)
            next_st = SQ_WAIT;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st         <= SQ_IDLE;
         mode       <= MODE_RST;
         pol        <= POL_RST;
         loadReg    <= CNT_W'(LOAD_RST);
         holdReg    <= CNT_W'(HOLD_RST);
         counter    <= CNT_W'(COUNT_RST);
         tc         <= 1'b0;
         secondHalf <= 1'b0;
      end else begin
         st         <= next_st;
         mode       <= next_mode;
         pol        <= next_pol;
         loadReg    <= next_load;
         holdReg    <= next_hold;
         counter    <= next_counter;
         tc         <= next_tc;
         secondHalf <= next_second;
      end
   end

   // outputs straight from registers and state
   assign tcOut    = tc;
   assign armedOut = (st != SQ_IDLE);
   assign countOut = counter;

endmodule

// File: test/cms_host_model.sv
`timescale 1ns/1ns
module cms_host_model (
   input  wire logic        ref_clk, // clock
   input  wire logic        hready,  // bus ready
   input  wire logic [31:0] hrdata,  // read data
   output logic             hsel,    // select
   output logic [31:0]      haddr,   // byte address
   output logic [1:0]       htrans,  // transfer type
   output logic             hwrite,  // write not read
   output logic [2:0]       hsize,   // word size
   output logic [31:0]      hwdata   // write data
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   task automatic addr_ph(input logic [7:0] a, input logic w);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge ref_clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= ~{24'h0, a};
   endtask

   // arming and programming only by bus writes
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_ph(a, 1'b1);
      hwdata <= d;
      do @(posedge ref_clk); while (hready !== 1'b1);
      hwdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      addr_ph(a, 1'b0);
      do @(posedge ref_clk); while (hready !== 1'b1);
      d = hrdata;
   endtask
endmodule

// File: test/cms_sequencer_props.sv
`timescale 1ns/1ns
module cms_sequencer_props #(
   parameter int CNT_W = cms_pkg::CNT_W_DEF // counter width
) (
   input wire logic             ref_clk,   // clock
   input wire logic             rst,       // sync reset
   input wire logic             ce,        // clock enable
   input wire logic             hsel,      // select
   input wire logic [1:0]       htrans,    // transfer type
   input wire logic             hwrite,    // write
   input wire logic             hready,    // bus ready
   input wire logic             hreadyout, // slave ready
   input wire logic             hresp,     // response
   input wire logic             srcIn,     // source
   input wire logic             gateIn,    // gate
   input wire logic             tcOut,     // terminal count
   input wire logic             armedOut,  // armed
   input wire logic [CNT_W-1:0] countOut   // counter
);
   logic take;
   logic wrPend;
   logic next_wrPend;
   assign take = hsel & htrans[1] & hready & ce;
   always_comb begin
      next_wrPend = ~rst & take & hwrite;
   end
   always_ff @(posedge ref_clk) begin
      wrPend <= next_wrPend;
   end
   ////////////////////////////////////////
   default clocking dc @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_write_nowait: assert property (take && hwrite |=> hreadyout)
      else $error("write stalled");
   chk_tc_zero: assert property (tcOut |-> countOut == '0)
      else $error("terminal count with nonzero counter");
   chk_tc_stands: assert property (tcOut && $stable(srcIn) && $stable(gateIn)
      && $past(srcIn) == $past(srcIn, 2) && !wrPend |=> tcOut)
      else $error("terminal count left without source edge");
   chk_arm_only_cmd: assert property (!armedOut && !wrPend |=> !armedOut)
      else $error("armed without command");
   chk_disarm_tc: assert property ($fell(armedOut) && !$past(wrPend) && !$past(rst)
      |-> ($past(tcOut) || $past(tcOut, 2)) && !tcOut)
      else $error("disarm not after terminal count");
   chk_idle_count: assert property (!armedOut && !tcOut && !wrPend |=> $stable(countOut))
      else $error("counted while disarmed");
   chk_count_step: assert property ($changed(countOut) && !$past(tcOut) && !$past(wrPend)
      && !$past(rst) && $past(gateIn) == $past(gateIn, 2)
      |-> countOut == CNT_W'($past(countOut) - 1))
      else $error("counter step not one");
   cover property (tcOut && armedOut);
   cover property ($fell(armedOut));
   cover property (tcOut && !gateIn);
endmodule

bind cms_sequencer cms_sequencer_props #(.CNT_W(CNT_W)) chk_u (
   .ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .srcIn(srcIn), .gateIn(gateIn),
   .tcOut(tcOut), .armedOut(armedOut), .countOut(countOut)
);

// File: test/cms_sequencer_tb.sv
`timescale 1ns/1ns
module cms_sequencer_tb;
   import cms_pkg::*;
   logic        ref_clk;
   logic        rst;
   logic        srcIn;
   logic        gateIn;
   logic        hsel;
   logic        hwrite;
   logic        hready;
   logic        hresp;
   logic        tcOut;
   logic        armedOut;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [15:0] countOut;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] rdv;
   logic [31:0] rnd;
   logic [2:0]  gk [3];
   int          err_total;
   int          n_checks;
   int          seed;
   int          mCnt, mLoad, mHold, mTc, mArm, mHalf, mLvl, mRep, mAlt, mPol;
   int          mSel, mCap, mEdge, mWait;

   cms_sequencer dut_u (
      .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .srcIn(srcIn), .gateIn(gateIn), .tcOut(tcOut), .armedOut(armedOut),
      .countOut(countOut)
   );
   cms_host_model host_u (
      .ref_clk(ref_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // model of one source transition
   task automatic step(input int rise);
      if (rise != mPol) return;
      if (mTc) begin
         mTc = 0;
         if (mAlt && !mHalf) begin
            mCnt = mHold;
            mHalf = 1;
         end else begin
            mCnt = (mSel && gateIn === 1'b1) ? mHold : mLoad;
            mHalf = 0;
            if (!mRep)
               mArm = 0;
            else if (mEdge)
               mWait = 1;
         end
      end else if (mArm && !mWait && (!mLvl || gateIn === 1'b1)) begin
         mCnt = mCnt - 1;
         mTc = (mCnt == 0);
      end
   endtask

   task automatic half(input logic v);
      logic g0;
      logic g;
      g0 = gateIn;
      g = v ? g0 : (mLvl ? 1'($random(seed)) : ~g0);
      @(posedge ref_clk);
      srcIn <= v;
      gateIn <= g;
      repeat (3) @(posedge ref_clk);
      // active gate edge, only ever together with a falling source transition
      if (g && !g0 && mArm) begin
         if (mCap) begin
            mHold = mCnt;
            mCnt = mLoad;
            mTc = 0;
         end else begin
            mWait = 0;
         end
      end
      step(v);
      chk(32'(countOut), mCnt, "count");
      chk(32'(tcOut), mTc, "tc");
      chk(32'(armedOut), mArm, "armed");
   endtask

   task automatic run(input logic [15:0] mode, input int pol, input int n, input string name);
      mLvl = mode[GATE_LSB+GATE_LEVEL_BIT];
      mRep = mode[REPEAT_BIT];
      mAlt = mode[RELOAD_BIT] & ~mode[SPECIAL_BIT];
      mSel = mode[RELOAD_BIT] & mode[SPECIAL_BIT];
      mCap = mode[SPECIAL_BIT] & ~mode[RELOAD_BIT];
      mEdge = (mode[GATE_MSB:GATE_LSB] != GATE_NONE) && !mLvl && !mCap;
      mWait = 0;
      mPol = pol;
      mLoad = 2 + ($unsigned($random(seed)) % 4);
      mHold = 1 + ($unsigned($random(seed)) % 3);
      mHalf = 0;
      host_u.wr(OFS_CMD, 32'h2);
      mArm = 0;
      host_u.wr(OFS_MODE, {16'h0, mode});
      host_u.wr(OFS_POL, 32'(2 | pol));
      host_u.wr(OFS_LOAD, mLoad);
      host_u.wr(OFS_HOLD, mHold);
      host_u.wr(OFS_CMD, 32'h4);
      mCnt = mLoad;
      mTc = 0;
      half(1'b1);
      half(1'b0);
      host_u.wr(OFS_CMD, 32'h1);
      mArm = 1;
      mWait = mEdge;
      @(posedge ref_clk);
      chk(32'(armedOut), 1, "arm");
      repeat (n) begin
         half(1'b1);
         half(1'b0);
      end
      host_u.rd(OFS_HOLD, rdv);
      chk(rdv, mHold, "hold");
      $display("test %s done", name);
   endtask

   initial begin
      seed = 32'h0319a8c2;
      gk = '{3'h0, 3'h4, 3'h1};
      rst = 1'b1;
      srcIn = 1'b0;
      gateIn = 1'b0;
      err_total = 0;
      n_checks = 0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      host_u.rd(OFS_MODE, rdv);
      chk(rdv, 32'(MODE_RST), "mode reset");
      host_u.rd(OFS_POL, rdv);
      chk(rdv, 32'(POL_RST), "pol reset");
      host_u.wr(8'h1C, $random(seed));
      host_u.rd(8'h1C, rdv);
      chk(rdv, 0, "unmapped");
      host_u.rd(OFS_CMD, rdv);
      chk(rdv, 0, "cmd read");
      $display("test registers done");
      for (int i = 0; i < 24; i++) begin
         // reserved letters are never programmed
         if (i inside {12, 15, 19, 20, 22}) continue;
         rnd = $random(seed);
         rnd = {16'h0, gk[i % 3], rnd[4:0], 1'(i / 12), 1'((i / 6) % 2), 1'((i / 3) % 2),
                rnd[9:5]};
         host_u.wr(OFS_MODE, rnd);
         host_u.rd(OFS_MODE, rdv);
         chk(rdv, rnd, "mode");
         host_u.rd(OFS_STATUS, rdv);
         chk(32'(rdv[12:8]), i, "letter");
      end
      $display("test mode letters done");
      run(16'h0000, 1, 8, "mode A rising");
      run(16'h0000, 0, 8, "mode A falling");
      run(16'h0020, 1, 12, "repeating");
      run(16'h8000, 1, 16, "level gate");
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      chk(32'(countOut), 0, "count reset");
      chk(32'(armedOut), 0, "armed reset");
      run(16'h0040, 1, 12, "alternating");
      run(16'h2020, 1, 12, "edge gate");
      run(16'h00E0, 1, 12, "gate select");
      run(16'h20A0, 1, 12, "capture");
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      stop_test();
   end
endmodule
